/* tb/fifo_ctrl_far_end.sv */
// Purpose: Far-side controller model driving the interface pins of the pin mux
// Assumes: refClk is the interface clock as seen at the pin
// Notes: Its clock stands still unless clkRun is high
`timescale 1ns/1ps

module fifo_ctrl_far_end (
  // Timing reference and clock request
  input wire logic refClk,
  input wire logic clkRun,
  // Requested pin levels
  input wire logic [1:0] selReq,
  input wire logic [2:0] rdyReq,
  // Pins toward the device
  output logic extClk,
  output logic [1:0] selPins,
  output logic [2:0] rdyPins
);
  // =====================================================================
  // External interface clock, off phase with every other clock
  initial begin
    extClk = 1'b0;
    #13;
    forever begin
      #40;
      extClk = clkRun ? !extClk : 1'b0;
    end
  end

  // Pins move on the falling edge so the device never samples them mid-change
  initial selPins = 2'h0;
  initial rdyPins = 3'h0;
  always @(negedge refClk) begin
    selPins <= selReq;
    rdyPins <= rdyReq;
  end
endmodule

/* tb/fifo_iface_ctrl_pin_mux_test.sv */
// Purpose: Self-checking bench for the interface pin mux
// Assumes: Internal 48 MHz source stands in for the 80 ns link clock
// Notes: Clock edges are offset so no sample lands on a source edge
`timescale 1ns/1ps
`include "iface_pin_cfg.svh"

module fifo_iface_ctrl_pin_mux_test;
  typedef struct {
    logic [1:0] mode;
    logic [1:0] sel;
    logic [3:0] prog, full, empty;
    logic [6:0] ctl, exp;
  } row_t;
  logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, intClk30, intClk48;
  logic awready, wready, bvalid, arready, rvalid, iface_clock_out, iface_clock_oe, linkClk;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, fifoProgLevel, fifoFull, fifoEmpty;
  logic [1:0] bresp, rresp, resp, fifoSelected, selReq, fifo_select_pins;
  logic [2:0] engineReady, rdyReq, rdyPins;
  logic [5:0] engineCtl;
  logic engineCtlThreeOe, clkRun, extClk, expClk;
  logic waveform_ctrl_out_zero, waveform_ctrl_out_one, waveform_ctrl_out_two;
  logic waveform_ctrl_out_three, waveform_ctrl_out_three_oe;
  logic waveform_ctrl_out_four, waveform_ctrl_out_five;
  wire logic iface_clock_in;
  wire logic ready_in_three, ready_in_four, ready_in_five;
  wire logic [31:0] pinsNow;
  wire logic [1:0] fifoSelPins;
  int err_total, n_compared, i, j;
  // Mode, select, levels, {pin3 oe, engine}, expected {pin3 oe, pins 5..0}
  row_t rows [10] = '{
    '{2'h0, 2'h0, 4'h0, 4'h0, 4'h0, 7'h15, 7'h7f}, '{2'h1, 2'h0, 4'h0, 4'h0, 4'h0, 7'h2a, 7'h7f},
    '{2'h2, 2'h0, 4'h0, 4'h0, 4'h0, 7'h15, 7'h15}, '{2'h2, 2'h0, 4'h0, 4'h0, 4'h0, 7'h6a, 7'h6a},
    '{2'h3, 2'h0, 4'h1, 4'h0, 4'h0, 7'h68, 7'h69}, '{2'h3, 2'h1, 4'h1, 4'h2, 4'h0, 7'h28, 7'h2a},
    '{2'h3, 2'h2, 4'h4, 4'h0, 4'h4, 7'h40, 7'h45}, '{2'h3, 2'h3, 4'h0, 4'h8, 4'h7, 7'h78, 7'h7a},
    '{2'h3, 2'h3, 4'h8, 4'h7, 4'h8, 7'h40, 7'h45}, '{2'h3, 2'h0, 4'he, 4'he, 4'he, 7'h47, 7'h40}};
  logic [7:0] regAddr [5] = '{`IFP_OFS_CONFIG, `IFP_OFS_IDLE, `IFP_OFS_FLAGSEL, 8'h10, 8'h1c};
  logic [31:0] regVal [5] = '{32'hc0, 32'h3f, 32'h24, 32'h0, 32'h0};
  logic [7:0] clkCfg [7] = '{8'hc0, 8'hd0, 8'h80, 8'h90, 8'h00, 8'h10, 8'he0};

  // =====================================================================
  // Pins: the clock pin is shared, the device wins while it drives
  assign iface_clock_in = iface_clock_oe ? iface_clock_out : extClk;
  assign {ready_in_five, ready_in_four, ready_in_three} = rdyPins;
  assign fifo_select_pins = fifoSelPins;
  assign pinsNow = {25'h0, waveform_ctrl_out_three_oe, waveform_ctrl_out_five,
    waveform_ctrl_out_four, waveform_ctrl_out_three, waveform_ctrl_out_two,
    waveform_ctrl_out_one, waveform_ctrl_out_zero};

  fifo_iface_ctrl_pin_mux fifo_iface_ctrl_pin_mux_inst (.mclk, .rst_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .intClk30, .intClk48,
    .iface_clock_in, .iface_clock_out, .iface_clock_oe, .linkClk, .ready_in_three,
    .ready_in_four, .ready_in_five, .engineReady, .engineCtl, .engineCtlThreeOe,
    .fifoProgLevel, .fifoFull, .fifoEmpty, .fifo_select_pins, .fifoSelected,
    .waveform_ctrl_out_zero, .waveform_ctrl_out_one, .waveform_ctrl_out_two,
    .waveform_ctrl_out_three, .waveform_ctrl_out_three_oe, .waveform_ctrl_out_four,
    .waveform_ctrl_out_five);

  fifo_ctrl_far_end fifo_ctrl_far_end_inst (.refClk(linkClk), .clkRun(clkRun),
    .selReq(selReq), .rdyReq(rdyReq), .extClk(extClk), .selPins(fifoSelPins),
    .rdyPins(rdyPins));

  // =====================================================================
  // Clocks, fractional offsets keep source edges away from the sample points
  initial begin
    mclk = 1'b0;
    forever #50 mclk = !mclk;
  end
  initial begin
    intClk48 = 1'b0;
    #7;
    forever #40 intClk48 = !intClk48;
  end
  initial begin
    intClk30 = 1'b0;
    #3.3;
    forever #64.5 intClk30 = !intClk30;
  end

  // Watchdog: a stalled link clock would otherwise hang a link-edge wait
  initial begin
    repeat (3000) @(posedge mclk);
    hang();
  end

  // =====================================================================
  // Checks and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic hang();
    err_total++;
    $display("[FAIL] t=%0t got %h exp %h", $time, 32'h0, 32'h1);
    end_sim();
  endtask

  // =====================================================================
  // Bus master: address and data offered together, each released when taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Reset: pins forced low while held, idle high once the link is out of reset
  task automatic resetPhase();
    int n;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    chk(pinsNow, 32'h40);
    @(posedge mclk);
    rst_n <= 1'b1;
    for (n = 0; n < 40 && pinsNow !== 32'h7f; n++) @(posedge mclk);
    chk(pinsNow, 32'h7f);
    $display("reset test done");
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, engineCtlThreeOe, clkRun} = 8'h00;
    {awaddr, araddr, wdata, wstrb, engineCtl} = 58'h0;
    wstrb = 4'hf;
    {fifoProgLevel, fifoFull, fifoEmpty, selReq, rdyReq} = 17'h0;
    resetPhase();
    // Reset values, then unmapped places answer with an error
    for (i = 0; i < 5; i++) begin
      axiRd(regAddr[i], rd, resp);
      chk(rd, regVal[i]);
      chk({30'h0, resp}, {30'h0, (i > 2) ? `IFP_RESP_SLVERR : `IFP_RESP_OKAY});
    end
    axiWr(8'h20, 32'hff, resp);
    chk({30'h0, resp}, {30'h0, `IFP_RESP_SLVERR});
    $display("register test done");
    // Table of modes, selections and levels
    for (i = 0; i < 10; i++) begin
      axiWr(`IFP_OFS_CONFIG, {24'h0, 6'h30, rows[i].mode}, resp);
      fifoProgLevel <= rows[i].prog;
      fifoFull <= rows[i].full;
      fifoEmpty <= rows[i].empty;
      selReq <= rows[i].sel;
      {engineCtlThreeOe, engineCtl} <= rows[i].ctl;
      repeat (6) @(posedge linkClk);
      #1;
      chk(pinsNow, {25'h0, rows[i].exp});
      chk({30'h0, fifoSelected}, {30'h0, rows[i].sel});
    end
    $display("mux table done");
    // Ready pins reach the engine and the status register
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      rdyReq <= i[0] ? 3'h2 : 3'h5;
      repeat (6) @(posedge linkClk);
      #1;
      chk({29'h0, engineReady}, {29'h0, i[0] ? 3'h2 : 3'h5});
      axiRd(`IFP_OFS_STATUS, rd, resp);
      chk({24'h0, rd[7:0]},
        {24'h0, rows[9].exp[2:0], rows[9].sel, i[0] ? 3'h2 : 3'h5});
    end
    $display("ready test done");
    // Idle levels, other flag sources and a write with byte 0 masked off
    axiWr(`IFP_OFS_IDLE, 32'h15, resp);
    wstrb <= 4'he;
    axiWr(`IFP_OFS_IDLE, 32'h2a, resp);
    chk({30'h0, resp}, {30'h0, `IFP_RESP_OKAY});
    wstrb <= 4'hf;
    axiRd(`IFP_OFS_IDLE, rd, resp);
    chk(rd, 32'h15);
    axiWr(`IFP_OFS_FLAGSEL, 32'h39, resp);
    axiWr(`IFP_OFS_CONFIG, 32'hc0, resp);
    selReq <= 2'h1;
    repeat (6) @(posedge linkClk);
    #1;
    chk(pinsNow, 32'h55);
    axiWr(`IFP_OFS_CONFIG, 32'hc3, resp);
    repeat (6) @(posedge linkClk);
    #1;
    chk(pinsNow, 32'h43);
    $display("flag source test done");
    // Clock source, rate select and inversion
    @(posedge mclk);
    clkRun <= 1'b1;
    for (i = 0; i < 7; i++) begin
      axiWr(`IFP_OFS_CONFIG, {24'h0, clkCfg[i]}, resp);
      for (j = 0; j < 3; j++) begin
        @(posedge mclk);
        #1;
        expClk = clkCfg[i][`IFP_CFG_INTERNAL] ?
          (clkCfg[i][`IFP_CFG_SEL48] ? intClk48 : intClk30) : extClk;
        chk({31'h0, linkClk}, {31'h0, expClk ^ clkCfg[i][`IFP_CFG_INVERT]});
        chk({31'h0, iface_clock_oe}, {31'h0, clkCfg[i][7] & clkCfg[i][5]});
        chk({31'h0, iface_clock_out}, {31'h0, expClk ^ clkCfg[i][`IFP_CFG_INVERT]});
      end
    end
    $display("clock test done");
    resetPhase();
    end_sim();
  end
endmodule

/* verilog/fifo_iface_ctrl_pin_mux.sv */
// Purpose: Pin mux for ready inputs, control outputs and interface clock
// Assumes: Register access over AXI4-Lite on mclk; link logic on the link clock
// Notes: Config levels cross by two flops and should change only when idle
`timescale 1ns/1ps
`include "iface_pin_cfg.svh"

module fifo_iface_ctrl_pin_mux (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [`IFP_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [`IFP_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Internal clock sources
  input wire logic intClk30,
  input wire logic intClk48,
  // Interface clock pin
  input wire logic iface_clock_in,
  output logic iface_clock_out,
  output logic iface_clock_oe,
  // Link clock seen by the waveform engine and FIFOs
  output logic linkClk,
  // Ready pins and their synchronised copies
  input wire logic ready_in_three,
  input wire logic ready_in_four,
  input wire logic ready_in_five,
  output logic [2:0] engineReady,
  // Waveform engine control, on the link clock
  input wire logic [5:0] engineCtl,
  input wire logic engineCtlThreeOe,
  // FIFO levels, on the link clock, one bit per FIFO
  input wire logic [3:0] fifoProgLevel,
  input wire logic [3:0] fifoFull,
  input wire logic [3:0] fifoEmpty,
  input wire logic [1:0] fifo_select_pins,
  output logic [1:0] fifoSelected,
  // Control and flag pins
  output logic waveform_ctrl_out_zero,
  output logic waveform_ctrl_out_one,
  output logic waveform_ctrl_out_two,
  output logic waveform_ctrl_out_three,
  output logic waveform_ctrl_out_three_oe,
  output logic waveform_ctrl_out_four,
  output logic waveform_ctrl_out_five
);

  // =====================================================================
  // Register bus slave
  logic awHeld;
  logic wHeld;
  logic [`IFP_ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic wStrbQ;
  logic doWrite;
  logic [7:0] iface_config_reg;
  logic [5:0] idleLevel;
  logic [5:0] flagSel;
  logic [7:0] statusSync;

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;

  // Address and data are held separately so they may arrive in any order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb[0]; // All fields sit in byte 0
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response follows both halves
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= `IFP_RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      case (awAddrQ)
        `IFP_OFS_CONFIG, `IFP_OFS_IDLE, `IFP_OFS_FLAGSEL, `IFP_OFS_STATUS: begin
          bresp <= `IFP_RESP_OKAY;
        end
        default: begin
          bresp <= `IFP_RESP_SLVERR;
        end
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Writable registers; status is read only and ignores writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      iface_config_reg <= `IFP_CFG_RST;
      idleLevel <= `IFP_IDLE_RST;
      flagSel <= `IFP_FLAGSEL_RST;
    end else if (doWrite && wStrbQ) begin
      case (awAddrQ)
        `IFP_OFS_CONFIG: begin
          iface_config_reg <= {wDataQ[7:4], 2'h0, wDataQ[1:0]};
        end
        `IFP_OFS_IDLE: begin
          idleLevel <= wDataQ[5:0];
        end
        `IFP_OFS_FLAGSEL: begin
          flagSel <= wDataQ[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data path; unmapped words read zero with an error
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `IFP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `IFP_RESP_OKAY;
      case (araddr)
        `IFP_OFS_CONFIG: rdata <= {24'h00_0000, iface_config_reg};
        `IFP_OFS_IDLE: rdata <= {26'h000_0000, idleLevel};
        `IFP_OFS_FLAGSEL: rdata <= {26'h000_0000, flagSel};
        `IFP_OFS_STATUS: rdata <= {24'h00_0000, statusSync};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `IFP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // =====================================================================
  // Interface clock
  iface_clk_gen u_clk_gen (
    .intClk30(intClk30),
    .intClk48(intClk48),
    .ifaceClockIn(iface_clock_in),
    .useInternal(iface_config_reg[`IFP_CFG_INTERNAL]),
    .sel48(iface_config_reg[`IFP_CFG_SEL48]),
    .invertClk(iface_config_reg[`IFP_CFG_INVERT]),
    .clockOutEn(iface_config_reg[`IFP_CFG_CLKOE]),
    .linkClk(linkClk),
    .ifaceClockOut(iface_clock_out),
    .ifaceClockOe(iface_clock_oe)
  );

  // =====================================================================
  // Link domain: reset, configuration and pin synchronisers
  logic linkRstMeta;
  logic linkRstN;
  logic [13:0] cfgMeta;
  logic [13:0] cfgLink;
  logic [2:0] readyMeta;
  logic [1:0] selMeta;
  iface_pin_pkg::iface_mode_t modeLink;
  logic [5:0] idleLink;
  logic [5:0] flagSelLink;
  logic [5:0] ctlQ;
  logic ctlThreeOeQ;
  logic [2:0] flagNext;

  // Link logic is clocked by the interface clock
  always_ff @(posedge linkClk) begin
    linkRstMeta <= rst_n;
    linkRstN <= linkRstMeta;
  end

  // Quasi-static levels; a change mid-frame may show one mixed cycle
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      cfgMeta <= 14'h0000;
      cfgLink <= {`IFP_IDLE_RST, `IFP_FLAGSEL_RST, 2'h0};
    end else begin
      cfgMeta <= {idleLevel, flagSel, iface_config_reg[1:0]};
      cfgLink <= cfgMeta;
    end
  end

  assign modeLink = iface_pin_pkg::iface_mode_t'(cfgLink[1:0]);
  assign flagSelLink = cfgLink[7:2];
  assign idleLink = cfgLink[13:8];

  // Ready pins feed the engine and the status register
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      readyMeta <= 3'h0;
      engineReady <= 3'h0;
    end else begin
      readyMeta <= {ready_in_five, ready_in_four, ready_in_three};
      engineReady <= readyMeta;
    end
  end

  // The far party drives the select pins, so they are synchronised
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      selMeta <= 2'h0;
      fifoSelected <= 2'h0;
    end else begin
      selMeta <= fifo_select_pins;
      fifoSelected <= selMeta;
    end
  end

  // =====================================================================
  // Flag sources
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      // Each flag shows the chosen condition of the selected FIFO
      always_comb begin
        unique case (iface_pin_pkg::flag_src_t'(flagSelLink[2*gi +: 2]))
          iface_pin_pkg::FLAG_PROG: flagNext[gi] = fifoProgLevel[fifoSelected];
          iface_pin_pkg::FLAG_FULL: flagNext[gi] = fifoFull[fifoSelected];
          iface_pin_pkg::FLAG_EMPTY: flagNext[gi] = fifoEmpty[fifoSelected];
          iface_pin_pkg::FLAG_NONE: flagNext[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // =====================================================================
  // Control pin mux
  // Pins 0-2 swap between engine and flags; 3-5 never carry flags
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      ctlQ <= 6'h00;
      ctlThreeOeQ <= 1'b1;
    end else begin
      unique case (modeLink)
        iface_pin_pkg::MODE_ENGINE: begin
          ctlQ <= engineCtl;
          ctlThreeOeQ <= engineCtlThreeOe;
        end
        iface_pin_pkg::MODE_FIFO: begin
          ctlQ <= {engineCtl[5:3], flagNext};
          ctlThreeOeQ <= engineCtlThreeOe;
        end
        iface_pin_pkg::MODE_IDLE, iface_pin_pkg::MODE_RSVD: begin
          ctlQ <= idleLink;
          ctlThreeOeQ <= 1'b1;
        end
      endcase
    end
  end

  // Reset gate forces pins low and the pin 3 enable high at once, even if the link clock stands still
  assign waveform_ctrl_out_zero = ctlQ[0] & rst_n;
  assign waveform_ctrl_out_one = ctlQ[1] & rst_n;
  assign waveform_ctrl_out_two = ctlQ[2] & rst_n;
  assign waveform_ctrl_out_three = ctlQ[3] & rst_n;
  assign waveform_ctrl_out_three_oe = ctlThreeOeQ | !rst_n;
  assign waveform_ctrl_out_four = ctlQ[4] & rst_n;
  assign waveform_ctrl_out_five = ctlQ[5] & rst_n;

  // =====================================================================
  // Status back to the bus clock
  logic [7:0] statusMeta;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      statusMeta <= 8'h00;
      statusSync <= 8'h00;
    end else begin
      statusMeta <= {ctlQ[2:0], fifoSelected, engineReady};
      statusSync <= statusMeta;
    end
  end

  // =====================================================================
  // Checks
  a_ready_sync: assert property (@(posedge linkClk) disable iff (!linkRstN)
    $past(linkRstN, 2) |->
      engineReady == $past({ready_in_five, ready_in_four, ready_in_three}, 2))
    else $error("ready pins not passed to engine after two flops");

  a_engine_route: assert property (@(posedge linkClk) disable iff (!linkRstN)
    $past(modeLink) == iface_pin_pkg::MODE_ENGINE |-> ctlQ == $past(engineCtl))
    else $error("engine control not routed to pins");

  a_flag_a_prog: assert property (@(posedge linkClk) disable iff (!linkRstN)
    ($past(modeLink) == iface_pin_pkg::MODE_FIFO) && ($past(flagSelLink[1:0]) == 2'h0)
      |-> ctlQ[0] == $past(fifoProgLevel[fifoSelected]))
    else $error("flag A does not show programmable level");

  a_flag_b_full: assert property (@(posedge linkClk) disable iff (!linkRstN)
    ($past(modeLink) == iface_pin_pkg::MODE_FIFO) && ($past(flagSelLink[3:2]) == 2'h1)
      |-> ctlQ[1] == $past(fifoFull[fifoSelected]))
    else $error("flag B does not show full");

  a_flag_c_empty: assert property (@(posedge linkClk) disable iff (!linkRstN)
    ($past(modeLink) == iface_pin_pkg::MODE_FIFO) && ($past(flagSelLink[5:4]) == 2'h2)
      |-> ctlQ[2] == $past(fifoEmpty[fifoSelected]))
    else $error("flag C does not show empty");

  a_upper_ctl: assert property (@(posedge linkClk) disable iff (!linkRstN)
    $past(modeLink) == iface_pin_pkg::MODE_FIFO
      |-> ctlQ[5:3] == $past(engineCtl[5:3]) && ctlThreeOeQ == $past(engineCtlThreeOe))
    else $error("upper control pins not driven by engine");

  a_reset_low: assert property (@(posedge linkClk) disable iff (!linkRstN)
    !rst_n |-> {waveform_ctrl_out_five, waveform_ctrl_out_four, waveform_ctrl_out_three,
      waveform_ctrl_out_two, waveform_ctrl_out_one, waveform_ctrl_out_zero} == 6'h00)
    else $error("control pins not low during reset");

  a_idle_high: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) ##1 (iface_config_reg[1:0] == 2'h0 && idleLevel == 6'h3f) [*3]
      |-> ##[0:40] (ctlQ == 6'h3f))
    else $error("control pins not high after reset");

  a_clk_source: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(doWrite && wStrbQ && awAddrQ == `IFP_OFS_CONFIG)
      |-> iface_clock_oe == ($past(wDataQ[7]) && $past(wDataQ[5])))
    else $error("clock pin drive does not follow internal source bits");

endmodule

/* verilog/iface_clk_gen.sv */
// Purpose: Selects and optionally inverts the interface clock
// Assumes: Config bits change only while the link is quiet
// Notes: Plain clock mux; switching sources may glitch the link clock
`timescale 1ns/1ps

module iface_clk_gen (
  // Clock sources
  input wire logic intClk30,
  input wire logic intClk48,
  input wire logic ifaceClockIn,
  // Configuration
  input wire logic useInternal,
  input wire logic sel48,
  input wire logic invertClk,
  input wire logic clockOutEn,
  // Results
  output logic linkClk,
  output logic ifaceClockOut,
  output logic ifaceClockOe
);

  logic baseClk;

  // Internal source picks 30 or 48 MHz, else the pin is the source
  always_comb begin
    if (useInternal) begin
      baseClk = sel48 ? intClk48 : intClk30;
    end else begin
      baseClk = ifaceClockIn;
    end
  end

  // Inversion applies to either source
  assign linkClk = baseClk ^ invertClk;
  assign ifaceClockOut = linkClk;
  // Only an internal source may drive the pin, else two drivers fight
  assign ifaceClockOe = useInternal & clockOutEn;

endmodule

/* verilog/iface_pin_cfg.svh */
// Purpose: Offsets, field positions and reset values of the interface pin mux
// Assumes: 32-bit register bus, byte addresses
// Notes: Definitions only
`ifndef IFACE_PIN_CFG_SVH
`define IFACE_PIN_CFG_SVH

// =====================================================================
// Register map
`define IFP_ADDR_W 8
`define IFP_OFS_CONFIG 8'h00
`define IFP_OFS_IDLE 8'h04
`define IFP_OFS_FLAGSEL 8'h08
`define IFP_OFS_STATUS 8'h0c

// =====================================================================
// Interface configuration fields
`define IFP_CFG_MODE_LSB 0
`define IFP_CFG_INVERT 4
`define IFP_CFG_CLKOE 5
`define IFP_CFG_SEL48 6
`define IFP_CFG_INTERNAL 7
`define IFP_CFG_RST 8'hc0

// =====================================================================
// Idle levels and flag sources
`define IFP_IDLE_RST 6'h3f
`define IFP_FLAGSEL_RST 6'h24

// =====================================================================
// Bus answers
`define IFP_RESP_OKAY 2'h0
`define IFP_RESP_SLVERR 2'h2

`endif

/* verilog/iface_pin_pkg.sv */
// Purpose: Types shared by the interface pin mux files
// Assumes: Nothing beyond the config header
// Notes: Constants live in iface_pin_cfg.svh
package iface_pin_pkg;

  // =====================================================================
  // Interface mode field
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_ENGINE = 2'h2,
    MODE_FIFO = 2'h3
  } iface_mode_t;

  // =====================================================================
  // Condition shown on a status flag pin
  typedef enum logic [1:0] {
    FLAG_PROG = 2'h0,
    FLAG_FULL = 2'h1,
    FLAG_EMPTY = 2'h2,
    FLAG_NONE = 2'h3
  } flag_src_t;

endpackage
